// File: verilog/rsd_pkg.sv
package rsd_pkg;

  // ****************************************************************
  // Register indices; byte address is four times the index
  // ****************************************************************
  localparam logic [15:0] IDX_RX_THRESHOLD_CFG = 16'hdf4f;
  localparam logic [15:0] IDX_CLEAR_OUT_CFG    = 16'hdf50;
  localparam logic [15:0] IDX_DELIM_OUT_CFG    = 16'hdf51;
  localparam logic [15:0] IDX_BUFFER_OUT_CFG   = 16'hdf52;
  localparam logic [15:0] IDX_DIE_REVISION     = 16'hdf60;
  localparam logic [15:0] IDX_PART_IDENTIFIER  = 16'hdf61;
  localparam logic [15:0] IDX_RADIO_STATUS     = 16'hdf62;
  localparam logic [15:0] IDX_CRYSTAL_TRIM     = 16'hdf63;
  localparam logic [15:0] IDX_ACK_IRQ_SELECT   = 16'hdf64;
  localparam logic [15:0] IDX_RADIO_POWER_CTRL = 16'hdf70;
  localparam logic [15:0] IDX_IRQ_STATUS       = 16'hdf71;
  localparam logic [15:0] IDX_IRQ_MASK         = 16'hdf72;

  localparam int          ADDR_W = 18;

  // ****************************************************************
  // Identification codes, values arbitrary
  // ****************************************************************
  localparam logic [7:0]  DIE_REVISION_CODE = 8'h5a;
  localparam logic [7:0]  PART_ID_CODE      = 8'h3c;

  // ****************************************************************
  // Reset values and field positions
  // ****************************************************************
  localparam logic [6:0]  RX_THRESHOLD_RST  = 7'h40;
  localparam logic [3:0]  CRYSTAL_TRIM_RST  = 4'hf;
  localparam logic [3:0]  PWR_DELAY_RST     = 4'h0;
  localparam int          ST_TX_ACTIVE      = 4;
  localparam int          ST_RX_NONEMPTY    = 3;
  localparam int          ST_RX_THRESHOLD   = 2;
  localparam int          ST_DELIMITER      = 1;
  localparam int          ST_CHANNEL_CLEAR  = 0;
  localparam int          CFG_OE            = 6;
  localparam int          CFG_POL           = 5;
  localparam int          BUF_THR_OE        = 3;
  localparam int          BUF_THR_POL       = 2;
  localparam int          BUF_NE_OE         = 1;
  localparam int          BUF_NE_POL        = 0;
  localparam int          PWR_PD            = 0;
  localparam int          PWR_STATE         = 1;
  localparam int          IRQ_TX_DONE       = 0;
  localparam int          IRQ_REG_READY     = 1;

  // ****************************************************************
  // Regulator power-on delay: (field + 1) steps
  // ****************************************************************
  localparam int          CLK_PERIOD_NS     = 100;
  localparam int          DELAY_STEP_NS     = 1600;
  localparam int          DELAY_STEP_CYC    = DELAY_STEP_NS / CLK_PERIOD_NS;

endpackage

// File: verilog/rsd_pwr_if.sv
interface rsd_pwr_if;
  logic       analog_reg_powerdown;
  logic [3:0] delay_sel;
  logic       ready_pulse;
  logic       reg_enabled;

  modport ctrl  (output analog_reg_powerdown, output delay_sel,
                 input ready_pulse, input reg_enabled);
  modport timer (input analog_reg_powerdown, input delay_sel,
                 output ready_pulse, output reg_enabled);
endinterface

// File: verilog/rsd_power_delay.sv
module rsd_power_delay
  import rsd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  rsd_pwr_if.timer pwr
);

  logic [11:0] cnt_reg;
  logic        running_reg;
  logic        enabled_reg;
  logic        pulse_reg;
  logic        pd_prev_reg;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pd_prev_reg <= 1'b1;
    end else begin
      pd_prev_reg <= pwr.analog_reg_powerdown;
    end
  end

  // Down-counter loaded on the clearing of the power-down bit
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt_reg     <= 12'h000;
      running_reg <= 1'b0;
      enabled_reg <= 1'b0;
      pulse_reg   <= 1'b0;
    end else if (pwr.analog_reg_powerdown) begin
      cnt_reg     <= 12'h000;
      running_reg <= 1'b0;
      enabled_reg <= 1'b0;
      pulse_reg   <= 1'b0;
    end else if (pd_prev_reg) begin
      cnt_reg     <= 12'((int'(pwr.delay_sel) + 1) * DELAY_STEP_CYC - 1);
      running_reg <= 1'b1;
      pulse_reg   <= 1'b0;
    end else if (running_reg && cnt_reg == 12'h000) begin
      running_reg <= 1'b0;
      enabled_reg <= 1'b1;
      pulse_reg   <= 1'b1;
    end else begin
      cnt_reg     <= running_reg ? cnt_reg - 12'h001 : cnt_reg;
      pulse_reg   <= 1'b0;
    end
  end

  assign pwr.ready_pulse = pulse_reg;
  assign pwr.reg_enabled = enabled_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  pd_disables_reg_a: assert property (
    pwr.analog_reg_powerdown |=> !pwr.reg_enabled)
    else $error("regulator enabled while powered down");

  enable_not_early_a: assert property (
    $fell(pwr.analog_reg_powerdown) |=> !pwr.reg_enabled [*8])
    else $error("regulator enabled before delay");

endmodule

// File: verilog/rsd_regs.sv
// Contract
// - Status bit 4 shows transmission in progress, read-only.
// - Status bit 3 shows receive buffer holds at least one byte.
// - Status bit 2 set when buffer count exceeds programmed threshold.
// - With filtering, threshold flag waits for pass; complete frame also sets it.
// - Status bit 1 shows frame delimiter, bit 0 channel clear.
// - Crystal trim bits 3:0, reset 1111, 1111 adds none, 0000 adds most.
// - Ack enable bit 0 lets transmitted ack frames set radio interrupt.
// - Part identifier is fixed 8-bit read-only code.
// - Die revision is 8-bit read-only silicon revision code.
// - Nonempty, threshold, delimiter, clear routable to port 1 pins 4..7.
// - Power-down bit disables analog regulator; clearing starts delay then enable.
// - Regulator-ready flag set when power-on delay expires.
// - Readable status bit shows delayed power-on state for polling.
// - Digital regulator off in either of two deepest sleep modes.
// - Registers keep contents while regulators are off.
// - Threshold level bits 6:0, reset 0x40, compared with buffer count.
// - Each debug output gated by own enable, xor with polarity bit.
//
// The implementer's own choice: register access over Avalon-MM.
module rsd_regs
  import rsd_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              tx_active,
  input  wire logic [7:0]        rx_buffer_count,
  input  wire logic              addr_filter_en,
  input  wire logic              frame_passed_filter,
  input  wire logic              frame_complete,
  input  wire logic              frame_delimiter_flag,
  input  wire logic              channel_clear_flag,
  input  wire logic              tx_frame_done,
  input  wire logic              tx_frame_is_ack,
  input  wire logic              deep_sleep_a,
  input  wire logic              deep_sleep_b,
  output logic      [3:0]        crystal_load_trim,
  output logic                   analog_reg_en,
  output logic                   digital_reg_en,
  output logic      [3:0]        dbg_pin_out,
  output logic      [3:0]        dbg_pin_oe_n,
  output logic                   irq
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [6:0] rx_threshold_level_reg;
  logic [6:0] clear_out_cfg_reg;
  logic [6:0] delim_out_cfg_reg;
  logic [3:0] buffer_out_cfg_reg;
  logic [3:0] crystal_load_trim_reg;
  logic       ack_tx_irq_enable_reg;
  logic       analog_reg_powerdown_reg;
  logic [3:0] pwr_delay_reg;
  logic [1:0] radio_irq_flags_reg;
  logic [1:0] radio_irq_flags_next;
  logic [1:0] irq_mask_reg;
  logic       ack_reg;
  logic [31:0] readdata_reg;
  logic [3:0] dbg_out_reg;
  logic [3:0] dbg_oe_n_reg;
  logic       irq_reg;

  logic [7:0] radio_status;
  logic       rx_nonempty;
  logic       rx_over_threshold;
  logic       rx_threshold_flag;
  logic       wr_fire;
  logic [7:0] wdata;
  logic       addr_hit;
  logic [7:0] rd_mux;
  logic       tx_irq_event;

  rsd_pwr_if pwr ();

  rsd_power_delay u_power_delay (
    .ref_clk (ref_clk),
    .srst    (srst),
    .pwr     (pwr.timer)
  );

  assign pwr.analog_reg_powerdown = analog_reg_powerdown_reg;
  assign pwr.delay_sel            = pwr_delay_reg;

  // ****************************************************************
  // Radio status
  // ****************************************************************
  assign rx_nonempty       = rx_buffer_count != 8'h00;
  assign rx_over_threshold = rx_buffer_count > {1'b0, rx_threshold_level_reg};
  // Filtering holds the flag back until the frame is accepted
  assign rx_threshold_flag = (rx_over_threshold && (!addr_filter_en || frame_passed_filter))
                             || frame_complete;

  always_comb begin
    radio_status                   = 8'h00;
    radio_status[ST_TX_ACTIVE]     = tx_active;
    radio_status[ST_RX_NONEMPTY]   = rx_nonempty;
    radio_status[ST_RX_THRESHOLD]  = rx_threshold_flag;
    radio_status[ST_DELIMITER]     = frame_delimiter_flag;
    radio_status[ST_CHANNEL_CLEAR] = channel_clear_flag;
  end

  // ****************************************************************
  // Avalon slave: one wait cycle, answer on the second
  // ****************************************************************
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign wr_fire         = avs_write && ack_reg && avs_byteenable[0];
  assign wdata           = avs_writedata[7:0];
  assign avs_readdata    = readdata_reg;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
    end
  end

  function automatic logic is_addr(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
    is_addr = a == ADDR_W'({idx, 2'b00});
  endfunction

  always_comb begin
    rd_mux   = 8'h00;
    addr_hit = 1'b1;
    if (is_addr(avs_address, IDX_RX_THRESHOLD_CFG)) begin
      rd_mux = {1'b0, rx_threshold_level_reg};
    end else if (is_addr(avs_address, IDX_CLEAR_OUT_CFG)) begin
      rd_mux = {1'b0, clear_out_cfg_reg};
    end else if (is_addr(avs_address, IDX_DELIM_OUT_CFG)) begin
      rd_mux = {1'b0, delim_out_cfg_reg};
    end else if (is_addr(avs_address, IDX_BUFFER_OUT_CFG)) begin
      rd_mux = {4'h0, buffer_out_cfg_reg};
    end else if (is_addr(avs_address, IDX_DIE_REVISION)) begin
      rd_mux = DIE_REVISION_CODE;
    end else if (is_addr(avs_address, IDX_PART_IDENTIFIER)) begin
      rd_mux = PART_ID_CODE;
    end else if (is_addr(avs_address, IDX_RADIO_STATUS)) begin
      rd_mux = radio_status;
    end else if (is_addr(avs_address, IDX_CRYSTAL_TRIM)) begin
      rd_mux = {4'h0, crystal_load_trim_reg};
    end else if (is_addr(avs_address, IDX_ACK_IRQ_SELECT)) begin
      rd_mux = {7'h00, ack_tx_irq_enable_reg};
    end else if (is_addr(avs_address, IDX_RADIO_POWER_CTRL)) begin
      rd_mux = {2'b00, pwr_delay_reg, !pwr.reg_enabled, analog_reg_powerdown_reg};
    end else if (is_addr(avs_address, IDX_IRQ_STATUS)) begin
      rd_mux = {6'h00, radio_irq_flags_reg};
    end else if (is_addr(avs_address, IDX_IRQ_MASK)) begin
      rd_mux = {6'h00, irq_mask_reg};
    end else begin
      addr_hit = 1'b0;
    end
  end

  // Latched in the wait cycle so it stands at the answering edge
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      readdata_reg <= 32'h0000_0000;
    end else if (avs_read && !ack_reg) begin
      readdata_reg <= addr_hit ? {24'h00_0000, rd_mux} : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Software-written registers; no sleep input touches them
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rx_threshold_level_reg <= RX_THRESHOLD_RST;
      clear_out_cfg_reg      <= 7'h00;
      delim_out_cfg_reg      <= 7'h00;
      buffer_out_cfg_reg     <= 4'h0;
    end else if (wr_fire) begin
      if (is_addr(avs_address, IDX_RX_THRESHOLD_CFG)) begin
        rx_threshold_level_reg <= wdata[6:0];
      end
      if (is_addr(avs_address, IDX_CLEAR_OUT_CFG)) begin
        clear_out_cfg_reg <= wdata[6:0];
      end
      if (is_addr(avs_address, IDX_DELIM_OUT_CFG)) begin
        delim_out_cfg_reg <= wdata[6:0];
      end
      if (is_addr(avs_address, IDX_BUFFER_OUT_CFG)) begin
        buffer_out_cfg_reg <= wdata[3:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      crystal_load_trim_reg <= CRYSTAL_TRIM_RST;
      ack_tx_irq_enable_reg <= 1'b0;
    end else if (wr_fire) begin
      if (is_addr(avs_address, IDX_CRYSTAL_TRIM)) begin
        crystal_load_trim_reg <= wdata[3:0];
      end
      if (is_addr(avs_address, IDX_ACK_IRQ_SELECT)) begin
        ack_tx_irq_enable_reg <= wdata[0];
      end
    end
  end

  // Regulator comes up powered down until software clears it
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      analog_reg_powerdown_reg <= 1'b1;
      pwr_delay_reg            <= PWR_DELAY_RST;
    end else if (wr_fire && is_addr(avs_address, IDX_RADIO_POWER_CTRL)) begin
      analog_reg_powerdown_reg <= wdata[PWR_PD];
      pwr_delay_reg            <= wdata[5:2];
    end
  end

  assign crystal_load_trim = crystal_load_trim_reg;
  assign analog_reg_en     = pwr.reg_enabled;
  assign digital_reg_en    = !(deep_sleep_a || deep_sleep_b);

  // ****************************************************************
  // Interrupt flags: set wins over write-one-to-clear
  // ****************************************************************
  assign tx_irq_event = tx_frame_done && (!tx_frame_is_ack || ack_tx_irq_enable_reg);

  always_comb begin
    radio_irq_flags_next = radio_irq_flags_reg;
    if (wr_fire && is_addr(avs_address, IDX_IRQ_STATUS)) begin
      radio_irq_flags_next = radio_irq_flags_reg & ~wdata[1:0];
    end
    if (tx_irq_event) begin
      radio_irq_flags_next[IRQ_TX_DONE] = 1'b1;
    end
    if (pwr.ready_pulse) begin
      radio_irq_flags_next[IRQ_REG_READY] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      radio_irq_flags_reg <= 2'b00;
    end else begin
      radio_irq_flags_reg <= radio_irq_flags_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_mask_reg <= 2'b00;
    end else if (wr_fire && is_addr(avs_address, IDX_IRQ_MASK)) begin
      irq_mask_reg <= wdata[1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(radio_irq_flags_next & irq_mask_reg);
    end
  end

  assign irq = irq_reg;

  // ****************************************************************
  // Debug pins: bit 0 pin 4 nonempty .. bit 3 pin 7 channel clear
  // ****************************************************************
  // Delimiter and clear need their selector at zero to reach the pin
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dbg_out_reg  <= 4'h0;
      dbg_oe_n_reg <= 4'hf;
    end else begin
      dbg_out_reg[0]  <= rx_nonempty ^ buffer_out_cfg_reg[BUF_NE_POL];
      dbg_out_reg[1]  <= rx_threshold_flag ^ buffer_out_cfg_reg[BUF_THR_POL];
      dbg_out_reg[2]  <= frame_delimiter_flag ^ delim_out_cfg_reg[CFG_POL];
      dbg_out_reg[3]  <= channel_clear_flag ^ clear_out_cfg_reg[CFG_POL];
      dbg_oe_n_reg[0] <= !buffer_out_cfg_reg[BUF_NE_OE];
      dbg_oe_n_reg[1] <= !buffer_out_cfg_reg[BUF_THR_OE];
      dbg_oe_n_reg[2] <= !(delim_out_cfg_reg[CFG_OE] && delim_out_cfg_reg[4:0] == 5'h00);
      dbg_oe_n_reg[3] <= !(clear_out_cfg_reg[CFG_OE] && clear_out_cfg_reg[4:0] == 5'h00);
    end
  end

  assign dbg_pin_out  = dbg_out_reg;
  assign dbg_pin_oe_n = dbg_oe_n_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence s_rd_part_id;
    avs_read && !ack_reg && is_addr(avs_address, IDX_PART_IDENTIFIER);
  endsequence

  sequence s_pd_cleared;
    $fell(analog_reg_powerdown_reg);
  endsequence

  status_tx_bit_a: assert property (radio_status[ST_TX_ACTIVE] == tx_active)
    else $error("tx active bit wrong");

  nonempty_bit_a: assert property (
    radio_status[ST_RX_NONEMPTY] == (rx_buffer_count != 8'h00))
    else $error("nonempty bit wrong");

  threshold_cmp_a: assert property (
    (!addr_filter_en && !frame_complete) |->
      radio_status[ST_RX_THRESHOLD] == (rx_buffer_count > {1'b0, rx_threshold_level_reg}))
    else $error("threshold flag wrong");

  filter_hold_a: assert property (
    (addr_filter_en && !frame_passed_filter && !frame_complete)
      |-> !radio_status[ST_RX_THRESHOLD])
    else $error("threshold flag before filter pass");

  part_id_read_a: assert property (s_rd_part_id |=> avs_readdata[7:0] == PART_ID_CODE)
    else $error("part identifier read wrong");

  ack_irq_gate_a: assert property (
    (tx_frame_done && tx_frame_is_ack && !ack_tx_irq_enable_reg
      && !radio_irq_flags_reg[IRQ_TX_DONE]) |=> !radio_irq_flags_reg[IRQ_TX_DONE])
    else $error("ack frame set interrupt while disabled");

  reg_ready_flag_a: assert property (
    pwr.ready_pulse |=> radio_irq_flags_reg[IRQ_REG_READY])
    else $error("regulator ready flag not set");

  pd_delay_min_a: assert property (s_pd_cleared |-> !analog_reg_en [*8])
    else $error("analog regulator enabled too soon");

  // Longest wait is the top delay setting plus load and enable cycles
  logic [8:0] pd_wait_reg;

  always_ff @(posedge ref_clk) begin
    if (srst || analog_reg_powerdown_reg || analog_reg_en) begin
      pd_wait_reg <= 9'h000;
    end else if (pd_wait_reg != 9'h1ff) begin
      pd_wait_reg <= pd_wait_reg + 9'h001;
    end
  end

  pd_delay_max_a: assert property (int'(pd_wait_reg) <= 16 * DELAY_STEP_CYC + 2)
    else $error("analog regulator never enabled");

  deep_sleep_a_off_a: assert property ((deep_sleep_a || deep_sleep_b) |-> !digital_reg_en)
    else $error("digital regulator on in deep sleep");

  dbg_polarity_a: assert property (
    buffer_out_cfg_reg[BUF_NE_OE] |=>
      dbg_pin_out[0] == ($past(rx_nonempty) ^ $past(buffer_out_cfg_reg[BUF_NE_POL])))
    else $error("debug pin level wrong");

  reserved_zero_a: assert property (radio_status[7:5] == 3'b000)
    else $error("reserved status bits set");

endmodule

// File: test/rsd_regs_bench.sv
module rsd_regs_bench
  import rsd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************************************
  // Register rows: optional write, then read back
  // ****************************************************************
  typedef struct packed {
    logic [15:0] idx;
    logic        wr;
    logic [7:0]  wdata;
    logic [7:0]  exp;
  } rsd_row_type;

  localparam rsd_row_type ROWS [17] = '{
    '{IDX_RADIO_STATUS,     1'b0, 8'h00, 8'h00},
    '{IDX_DIE_REVISION,     1'b0, 8'h00, DIE_REVISION_CODE},
    '{IDX_PART_IDENTIFIER,  1'b0, 8'h00, PART_ID_CODE},
    '{IDX_CRYSTAL_TRIM,     1'b0, 8'h00, 8'h0f},
    '{IDX_ACK_IRQ_SELECT,   1'b0, 8'h00, 8'h00},
    '{IDX_RX_THRESHOLD_CFG, 1'b0, 8'h00, 8'h40},
    '{IDX_CLEAR_OUT_CFG,    1'b0, 8'h00, 8'h00},
    '{IDX_RADIO_POWER_CTRL, 1'b0, 8'h00, 8'h03},
    '{IDX_IRQ_STATUS,       1'b0, 8'h00, 8'h00},
    '{IDX_IRQ_MASK,         1'b0, 8'h00, 8'h00},
    '{IDX_PART_IDENTIFIER,  1'b1, 8'hff, PART_ID_CODE},
    '{IDX_DIE_REVISION,     1'b1, 8'h00, DIE_REVISION_CODE},
    '{IDX_CRYSTAL_TRIM,     1'b1, 8'ha5, 8'h05},
    '{IDX_ACK_IRQ_SELECT,   1'b1, 8'hff, 8'h01},
    '{IDX_RX_THRESHOLD_CFG, 1'b1, 8'hff, 8'h7f},
    '{IDX_DELIM_OUT_CFG,    1'b1, 8'hff, 8'h7f},
    '{16'hdf65,             1'b1, 8'hff, 8'h00}
  };

  logic              ref_clk;
  logic              srst;
  logic [ADDR_W-1:0] avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [31:0]       avs_writedata;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic              tx_active;
  logic [7:0]        rx_buffer_count;
  logic [4:0]        radio_flags;
  logic              tx_frame_done;
  logic              tx_frame_is_ack;
  logic              deep_sleep_a;
  logic              deep_sleep_b;
  logic [3:0]        crystal_load_trim;
  logic              analog_reg_en;
  logic              digital_reg_en;
  logic [3:0]        dbg_pin_out;
  logic [3:0]        dbg_pin_oe_n;
  logic              irq;
  logic [31:0]       rd;
  int                failures;
  int                comparisons;
  int                cyc;

  rsd_regs uut (
    .ref_clk(ref_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .tx_active(tx_active), .rx_buffer_count(rx_buffer_count),
    .addr_filter_en(radio_flags[4]), .frame_passed_filter(radio_flags[3]),
    .frame_complete(radio_flags[2]), .frame_delimiter_flag(radio_flags[1]),
    .channel_clear_flag(radio_flags[0]), .tx_frame_done(tx_frame_done),
    .tx_frame_is_ack(tx_frame_is_ack), .deep_sleep_a(deep_sleep_a),
    .deep_sleep_b(deep_sleep_b), .crystal_load_trim(crystal_load_trim),
    .analog_reg_en(analog_reg_en), .digital_reg_en(digital_reg_en),
    .dbg_pin_out(dbg_pin_out), .dbg_pin_oe_n(dbg_pin_oe_n), .irq(irq)
  );

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ****************************************************************
  // Compare, bus and stimulus tasks
  // ****************************************************************
  task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_bit(input string name, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus_xfer(input logic wr, input logic [15:0] idx, input logic [7:0] data,
                          output logic [31:0] rdata);
    @(posedge ref_clk);
    avs_address   <= {idx, 2'b00};
    avs_writedata <= {24'h0, data};
    avs_write     <= wr;
    avs_read      <= !wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic settle();
    repeat (3) @(negedge ref_clk);
  endtask

  task automatic status_case(input logic tx, input logic [7:0] cnt, input logic [4:0] f,
                             input logic [7:0] exp);
    @(posedge ref_clk);
    tx_active       <= tx;
    rx_buffer_count <= cnt;
    radio_flags     <= f;
    bus_xfer(1'b0, IDX_RADIO_STATUS, 8'h00, rd);
    check_val("radio_status", {24'h0, exp}, rd);
  endtask

  task automatic frame_done(input logic is_ack);
    @(posedge ref_clk);
    tx_frame_done   <= 1'b1;
    tx_frame_is_ack <= is_ack;
    @(posedge ref_clk);
    tx_frame_done <= 1'b0;
    settle();
  endtask

  // Loose window: the counter load adds a cycle or two of slack
  task automatic time_power_on(input int field);
    cyc = 0;
    while (analog_reg_en !== 1'b1 && cyc < 300) begin
      @(negedge ref_clk);
      cyc++;
    end
    check_bit("power-on delay", 1'b1, (cyc >= (field + 1) * DELAY_STEP_CYC)
              && (cyc <= (field + 1) * DELAY_STEP_CYC + 4));
  endtask

  task automatic complete_run();
    if (failures == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    complete_run();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {srst, avs_read, avs_write, tx_frame_done, tx_frame_is_ack} = 5'h10;
    {avs_address, avs_writedata, tx_active, rx_buffer_count, radio_flags} = '0;
    {deep_sleep_a, deep_sleep_b, failures, comparisons} = '0;
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    @(negedge ref_clk);
    check_bit("irq", 1'b0, irq);
    check_bit("analog_reg_en", 1'b0, analog_reg_en);
    check_val("dbg_pin_oe_n", 32'hf, {28'h0, dbg_pin_oe_n});
    check_val("trim pins", 32'hf, {28'h0, crystal_load_trim});
    foreach (ROWS[i]) begin
      if (ROWS[i].wr) bus_xfer(1'b1, ROWS[i].idx, ROWS[i].wdata, rd);
      bus_xfer(1'b0, ROWS[i].idx, 8'h00, rd);
      check_val($sformatf("reg %h", ROWS[i].idx), {24'h0, ROWS[i].exp}, rd);
    end
    check_val("trim pins", 32'h5, {28'h0, crystal_load_trim});
    bus_xfer(1'b1, IDX_RX_THRESHOLD_CFG, 8'h10, rd);
    status_case(1'b1, 8'h00, 5'h00, 8'h10);
    status_case(1'b0, 8'h01, 5'h00, 8'h08);
    status_case(1'b0, 8'h10, 5'h00, 8'h08);
    status_case(1'b0, 8'h11, 5'h00, 8'h0c);
    status_case(1'b0, 8'h11, 5'h10, 8'h08);
    status_case(1'b0, 8'h11, 5'h18, 8'h0c);
    status_case(1'b0, 8'h00, 5'h04, 8'h04);
    status_case(1'b0, 8'h00, 5'h02, 8'h02);
    status_case(1'b0, 8'h00, 5'h01, 8'h01);
    bus_xfer(1'b1, IDX_CLEAR_OUT_CFG, 8'h60, rd);
    bus_xfer(1'b1, IDX_DELIM_OUT_CFG, 8'h40, rd);
    bus_xfer(1'b1, IDX_BUFFER_OUT_CFG, 8'h0b, rd);
    status_case(1'b0, 8'h01, 5'h03, 8'h0b);
    check_val("dbg_pin_oe_n", 32'h0, {28'h0, dbg_pin_oe_n});
    check_val("dbg_pin_out", 32'h4, {28'h0, dbg_pin_out});
    bus_xfer(1'b1, IDX_CLEAR_OUT_CFG, 8'h41, rd);
    settle();
    check_val("dbg_pin_oe_n", 32'h8, {28'h0, dbg_pin_oe_n});
    // Transmit-done interrupt, ack frames gated by the select bit
    bus_xfer(1'b1, IDX_IRQ_MASK, 8'h03, rd);
    bus_xfer(1'b1, IDX_ACK_IRQ_SELECT, 8'h00, rd);
    frame_done(1'b1);
    check_bit("irq", 1'b0, irq);
    frame_done(1'b0);
    check_bit("irq", 1'b1, irq);
    bus_xfer(1'b1, IDX_IRQ_STATUS, 8'h01, rd);
    settle();
    check_bit("irq", 1'b0, irq);
    bus_xfer(1'b1, IDX_ACK_IRQ_SELECT, 8'h01, rd);
    frame_done(1'b1);
    bus_xfer(1'b0, IDX_IRQ_STATUS, 8'h00, rd);
    check_val("irq status", 32'h1, rd);
    bus_xfer(1'b1, IDX_IRQ_MASK, 8'h02, rd);
    settle();
    check_bit("irq", 1'b0, irq);
    bus_xfer(1'b1, IDX_IRQ_STATUS, 8'h01, rd);
    // Regulator power-on, shortest then next delay setting
    bus_xfer(1'b1, IDX_RADIO_POWER_CTRL, 8'h00, rd);
    time_power_on(0);
    bus_xfer(1'b0, IDX_RADIO_POWER_CTRL, 8'h00, rd);
    check_val("power ctrl", 32'h0, rd);
    bus_xfer(1'b0, IDX_IRQ_STATUS, 8'h00, rd);
    check_val("irq status", 32'h2, rd);
    check_bit("irq", 1'b1, irq);
    bus_xfer(1'b1, IDX_IRQ_STATUS, 8'h02, rd);
    bus_xfer(1'b1, IDX_RADIO_POWER_CTRL, 8'h01, rd);
    settle();
    check_bit("analog_reg_en", 1'b0, analog_reg_en);
    bus_xfer(1'b0, IDX_RADIO_POWER_CTRL, 8'h00, rd);
    check_val("power ctrl", 32'h3, rd);
    bus_xfer(1'b1, IDX_RADIO_POWER_CTRL, 8'h04, rd);
    time_power_on(1);
    // Deep sleep drops the digital supply but keeps register state
    bus_xfer(1'b1, IDX_CRYSTAL_TRIM, 8'h00, rd);
    deep_sleep_a <= 1'b1;
    settle();
    check_bit("digital_reg_en", 1'b0, digital_reg_en);
    @(posedge ref_clk);
    deep_sleep_a <= 1'b0;
    deep_sleep_b <= 1'b1;
    settle();
    check_bit("digital_reg_en", 1'b0, digital_reg_en);
    @(posedge ref_clk);
    deep_sleep_b <= 1'b0;
    settle();
    check_bit("digital_reg_en", 1'b1, digital_reg_en);
    bus_xfer(1'b0, IDX_CRYSTAL_TRIM, 8'h00, rd);
    check_val("trim after sleep", 32'h0, rd);
    check_val("trim pins", 32'h0, {28'h0, crystal_load_trim});
    // Reset in mid-run restores defaults
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    @(negedge ref_clk);
    check_val("trim pins", 32'hf, {28'h0, crystal_load_trim});
    check_bit("analog_reg_en", 1'b0, analog_reg_en);
    bus_xfer(1'b0, IDX_IRQ_STATUS, 8'h00, rd);
    check_val("irq status", 32'h0, rd);
    complete_run();
  end
endmodule
